// [block_ram_tile_pkg.sv]
// Shared constants and types for the block RAM tile
package block_ram_tile_pkg;

    // ------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------
    localparam int TILE_BITS = 4608;
    localparam int TILE_COUNT = 14;
    localparam int MAX_WIDTH = 36;
    localparam int ADDR_W = 12;
    localparam int BIT_W = 13;
    localparam int STREAM_DEPTH = 4;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [4:0] REG_CONFIG = 5'h00;
    localparam logic [4:0] REG_LOAD_ADDR = 5'h04;
    localparam logic [4:0] REG_LOAD_LOW = 5'h08;
    localparam logic [4:0] REG_LOAD_HIGH = 5'h0C;
    localparam logic [4:0] REG_STATUS = 5'h10;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_RATIO_LSB = 2;
    localparam int CFG_WB_LSB = 5;
    localparam int CFG_OUTREG_BIT = 7;
    localparam int CFG_WLOCK_BIT = 8;
    localparam int CFG_W = 9;
    localparam logic [8:0] CONFIG_RESET = 9'h000;
    localparam int ST_EMPTY_BIT = 0;
    localparam int ST_FULL_BIT = 1;
    localparam int ST_CLAMP_BIT = 2;
    localparam int ST_COUNT_LSB = 16;
    localparam int LOAD_HIGH_W = 4;

    // ------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b00,
        MODE_TRUE_DUAL = 2'b01,
        MODE_PSEUDO_DUAL = 2'b10,
        MODE_FIFO = 2'b11
    } mode_e;

    typedef enum logic [2:0] {
        RATIO_4096X1 = 3'b000,
        RATIO_2048X2 = 3'b001,
        RATIO_1024X4 = 3'b010,
        RATIO_512X9 = 3'b011,
        RATIO_256X18 = 3'b100,
        RATIO_128X36 = 3'b101
    } ratio_e;

    typedef enum logic [1:0] {
        WB_NORMAL = 2'b00,
        WB_THROUGH = 2'b01,
        WB_READ_FIRST = 2'b10
    } write_mode_e;

endpackage

// [stream_fifo.sv]
// Small valid/ready FIFO used in the tile's push path
`timescale 1ns/1ps
module stream_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 4
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] slots [0:DEPTH-1];
    logic [PW-1:0] head;
    logic [PW-1:0] tail;
    logic [CW-1:0] count;
    logic take;
    logic give;

    assign in_ready = (count != CW'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = slots[head];
    assign take = in_valid && in_ready;
    assign give = out_valid && out_ready;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        if (p == PW'(DEPTH - 1)) begin
            return '0;
        end
        return p + 1'b1;
    endfunction

    always_ff @(posedge clock) begin
        if (take) begin
            slots[tail] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            head <= '0;
            tail <= '0;
            count <= '0;
        end else begin
            if (take) begin
                tail <= bump(tail);
            end
            if (give) begin
                head <= bump(head);
            end
            if (take && !give) begin
                count <= count + 1'b1;
            end else if (give && !take) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// [block_ram_tile.sv]
// Configurable block RAM tile: RAM ports, FIFO mode and preload port
//
// Operation
// RULE1: One 4.5 kbit array, input and output registers.
// RULE2: Single, true dual, pseudo dual or FIFO.
// RULE3: Six aspect ratios; true dual stops 256x18.
// RULE4: Address and write data registered before array.
// RULE5: Optional output register adds one cycle.
// RULE6: Normal mode holds output during writes.
// RULE7: Write-through shows written data on output.
// RULE8: Read-before-write shows old stored value.
// RULE9: Contents preloadable before user operation.
// RULE10: ROM use: preload, write enables held off.
// RULE11: User logic may gang tiles deeper, wider.
// RULE12: FIFO flags; write when full, read when empty ignored. Pushes while full are still taken into the 4-word push buffer.
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module block_ram_tile (
    input wire logic clock,
    input wire logic reset,
    input wire logic [4:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic a_enable,
    input wire logic a_write,
    input wire logic [11:0] a_addr,
    input wire logic [35:0] a_wdata,
    output logic [35:0] a_rdata,
    input wire logic b_enable,
    input wire logic b_write,
    input wire logic [11:0] b_addr,
    input wire logic [35:0] b_wdata,
    output logic [35:0] b_rdata,
    input wire logic push_valid,
    output logic push_ready,
    input wire logic [35:0] push_data,
    input wire logic pop_request,
    output logic pop_valid,
    output logic [35:0] pop_data,
    output logic fifo_full,
    output logic fifo_empty
);
    // ------------------------------------------------------------
    // Storage (one tile; a device holds fourteen of these)
    // ------------------------------------------------------------
    // No reset on the array: preloaded words must survive reset
    logic mem [0:block_ram_tile_pkg::TILE_BITS-1]; // see RULE1

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [block_ram_tile_pkg::CFG_W-1:0] config_q;
    logic [11:0] load_addr;
    logic [3:0] load_high;
    logic [1:0] mode;
    logic [2:0] ratio_raw;
    logic [2:0] ratio;
    logic [1:0] wb_mode;
    logic out_reg_on;
    logic write_lock;
    logic ratio_clamped;
    logic config_write;
    logic load_write;

    assign mode = config_q[block_ram_tile_pkg::CFG_MODE_LSB +: 2];
    assign ratio_raw = config_q[block_ram_tile_pkg::CFG_RATIO_LSB +: 3];
    assign wb_mode = config_q[block_ram_tile_pkg::CFG_WB_LSB +: 2];
    assign out_reg_on = config_q[block_ram_tile_pkg::CFG_OUTREG_BIT];
    assign write_lock = config_q[block_ram_tile_pkg::CFG_WLOCK_BIT];
    assign config_write = reg_write
        && (reg_addr == block_ram_tile_pkg::REG_CONFIG);
    assign load_write = reg_write
        && (reg_addr == block_ram_tile_pkg::REG_LOAD_LOW);

    // Ratios above 128x36 fold to 128x36; true dual has no 36 bit port
    always_comb begin
        ratio_clamped = 1'b0;
        ratio = ratio_raw;
        if (ratio_raw > block_ram_tile_pkg::RATIO_128X36) begin
            ratio = block_ram_tile_pkg::RATIO_128X36; // see RULE3
            ratio_clamped = 1'b1;
        end
        if (mode == block_ram_tile_pkg::MODE_TRUE_DUAL
            && ratio == block_ram_tile_pkg::RATIO_128X36) begin
            ratio = block_ram_tile_pkg::RATIO_256X18; // see RULE3
            ratio_clamped = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Geometry helpers
    // ------------------------------------------------------------
    function automatic logic [5:0] width_of(input logic [2:0] r);
        case (r)
            3'h0: return 6'h01;
            3'h1: return 6'h02;
            3'h2: return 6'h04;
            3'h3: return 6'h09;
            3'h4: return 6'h12;
            default: return 6'h24;
        endcase
    endfunction

    function automatic logic [12:0] depth_of(input logic [2:0] r);
        return 13'h1000 >> r; // see RULE3
    endfunction

    // Address bits above the depth are ignored, so the port wraps
    function automatic logic [12:0] base_of(input logic [11:0] addr,
                                            input logic [2:0] r);
        logic [11:0] masked;
        logic [17:0] product;
        masked = addr & 12'(depth_of(r) - 13'h0001);
        product = 18'(masked) * 18'(width_of(r));
        return product[12:0];
    endfunction

    function automatic logic [35:0] read_word(input logic [12:0] base,
                                              input logic [2:0] r);
        logic [35:0] word;
        word = '0;
        for (int j = 0; j < block_ram_tile_pkg::MAX_WIDTH; j++) begin
            if (6'(j) < width_of(r)) begin
                word[j] = mem[base + 13'(j)];
            end
        end
        return word;
    endfunction

    function automatic logic [35:0] trim(input logic [35:0] d,
                                         input logic [2:0] r);
        return d & ((36'h1 << width_of(r)) - 36'h1);
    endfunction

    // ------------------------------------------------------------
    // Push path buffer and FIFO bookkeeping
    // ------------------------------------------------------------
    logic drain_valid;
    logic drain_ready;
    logic [35:0] drain_data;
    logic [11:0] wr_ptr;
    logic [11:0] rd_ptr;
    logic [12:0] count;
    logic fifo_mode;
    logic push_take;
    logic pop_take;

    assign fifo_mode = (mode == block_ram_tile_pkg::MODE_FIFO);
    assign fifo_full = (count == depth_of(ratio)); // see RULE12
    assign fifo_empty = (count == 13'h0000); // see RULE12
    // Preload owns the write port for its cycle, so the drain waits
    assign drain_ready = fifo_mode && !fifo_full && !load_write;
    assign push_take = drain_valid && drain_ready; // see RULE12
    assign pop_take = fifo_mode && pop_request && !fifo_empty; // see RULE12

    stream_fifo #(
        .WIDTH(block_ram_tile_pkg::MAX_WIDTH),
        .DEPTH(block_ram_tile_pkg::STREAM_DEPTH)
    ) push_buffer (
        .clock(clock),
        .reset(reset),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_data),
        .out_valid(drain_valid),
        .out_ready(drain_ready),
        .out_data(drain_data)
    );

    function automatic logic [11:0] advance(input logic [11:0] p,
                                            input logic [2:0] r);
        if (13'(p) == depth_of(r) - 13'h0001) begin
            return 12'h000;
        end
        return p + 12'h001;
    endfunction

    // Reconfiguring restarts the queue; old words are not reinterpreted
    always_ff @(posedge clock) begin
        if (reset || config_write) begin
            wr_ptr <= 12'h000;
            rd_ptr <= 12'h000;
            count <= 13'h0000;
        end else begin
            if (push_take) begin
                wr_ptr <= advance(wr_ptr, ratio);
            end
            if (pop_take) begin
                rd_ptr <= advance(rd_ptr, ratio);
            end
            if (push_take && !pop_take) begin
                count <= count + 13'h0001;
            end else if (pop_take && !push_take) begin
                count <= count - 13'h0001;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            pop_valid <= 1'b0;
            pop_data <= '0;
        end else begin
            pop_valid <= pop_take;
            if (pop_take) begin
                pop_data <= read_word(base_of(rd_ptr, ratio), ratio);
            end
        end
    end

    // ------------------------------------------------------------
    // Write arbitration
    // ------------------------------------------------------------
    logic a_wr;
    logic b_wr;
    logic a_rd;
    logic b_rd;
    logic wr0_en;
    logic [12:0] wr0_base;
    logic [35:0] wr0_data;
    logic wr1_en;
    logic [12:0] base_a;
    logic [12:0] base_b;

    // A locked tile is a ROM: write strobes turn into reads, except on port A in pseudo dual mode, where they do nothing
    assign a_wr = a_enable && a_write && !write_lock && !fifo_mode; // see RULE10
    assign b_wr = b_enable && b_write && !write_lock // see RULE10
        && (mode == block_ram_tile_pkg::MODE_TRUE_DUAL);
    assign a_rd = a_enable && !a_wr && !fifo_mode
        && (mode != block_ram_tile_pkg::MODE_PSEUDO_DUAL);
    assign b_rd = b_enable && !b_wr
        && (mode == block_ram_tile_pkg::MODE_TRUE_DUAL
            || mode == block_ram_tile_pkg::MODE_PSEUDO_DUAL); // see RULE2
    assign base_a = base_of(a_addr, ratio);
    assign base_b = base_of(b_addr, ratio);

    always_comb begin
        wr0_en = 1'b0;
        wr0_base = base_a;
        wr0_data = a_wdata;
        if (load_write) begin
            wr0_en = 1'b1; // see RULE9
            wr0_base = base_of(load_addr, ratio);
            wr0_data = {load_high, reg_wdata};
        end else if (push_take) begin
            wr0_en = 1'b1;
            wr0_base = base_of(wr_ptr, ratio);
            wr0_data = drain_data;
        end else if (a_wr) begin
            wr0_en = 1'b1;
        end
    end
    assign wr1_en = b_wr;

    // Array written at the clock edge that captures address and data,
    // which is the input register; port B wins a same-cell collision
    always_ff @(posedge clock) begin
        for (int j = 0; j < block_ram_tile_pkg::MAX_WIDTH; j++) begin
            if (wr0_en && 6'(j) < width_of(ratio)) begin
                mem[wr0_base + 13'(j)] <= wr0_data[j]; // see RULE4
            end
            if (wr1_en && 6'(j) < width_of(ratio)) begin
                mem[base_b + 13'(j)] <= b_wdata[j]; // see RULE4
            end
        end
    end

    // ------------------------------------------------------------
    // Port output stages
    // ------------------------------------------------------------
    logic [35:0] a_stage;
    logic [35:0] b_stage;
    logic [35:0] a_out_q;
    logic [35:0] b_out_q;

    always_ff @(posedge clock) begin
        if (reset) begin
            a_stage <= '0;
        end else if (a_wr) begin
            case (wb_mode)
                block_ram_tile_pkg::WB_THROUGH: begin
                    a_stage <= trim(a_wdata, ratio); // see RULE7
                end
                block_ram_tile_pkg::WB_READ_FIRST: begin
                    a_stage <= read_word(base_a, ratio); // see RULE8
                end
                default: begin
                    a_stage <= a_stage; // see RULE6
                end
            endcase
        end else if (a_rd) begin
            a_stage <= read_word(base_a, ratio);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            b_stage <= '0;
        end else if (b_wr) begin
            case (wb_mode)
                block_ram_tile_pkg::WB_THROUGH: begin
                    b_stage <= trim(b_wdata, ratio); // see RULE7
                end
                block_ram_tile_pkg::WB_READ_FIRST: begin
                    b_stage <= read_word(base_b, ratio); // see RULE8
                end
                default: begin
                    b_stage <= b_stage; // see RULE6
                end
            endcase
        end else if (b_rd) begin
            b_stage <= read_word(base_b, ratio);
        end
    end

    // Output register trades a cycle of latency for timing slack
    always_ff @(posedge clock) begin
        if (reset) begin
            a_out_q <= '0;
            b_out_q <= '0;
        end else begin
            a_out_q <= a_stage; // see RULE5
            b_out_q <= b_stage; // see RULE5
        end
    end

    assign a_rdata = out_reg_on ? a_out_q : a_stage; // see RULE5
    assign b_rdata = out_reg_on ? b_out_q : b_stage; // see RULE5

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            config_q <= block_ram_tile_pkg::CONFIG_RESET;
        end else if (config_write) begin
            config_q <= reg_wdata[block_ram_tile_pkg::CFG_W-1:0]; // see RULE2
        end
    end

    // Load address steps after each word so a burst fills the array
    always_ff @(posedge clock) begin
        if (reset) begin
            load_addr <= 12'h000;
            load_high <= 4'h0;
        end else if (reg_write
                     && reg_addr == block_ram_tile_pkg::REG_LOAD_ADDR) begin
            load_addr <= reg_wdata[11:0];
        end else if (reg_write
                     && reg_addr == block_ram_tile_pkg::REG_LOAD_HIGH) begin
            load_high <= reg_wdata[3:0];
        end else if (load_write) begin
            load_addr <= load_addr + 12'h001; // see RULE9
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_read) begin
            reg_rdata <= 32'h0000_0000;
            case (reg_addr)
                block_ram_tile_pkg::REG_CONFIG: begin
                    reg_rdata[block_ram_tile_pkg::CFG_W-1:0] <= config_q;
                end
                block_ram_tile_pkg::REG_LOAD_ADDR: begin
                    reg_rdata[11:0] <= load_addr;
                end
                block_ram_tile_pkg::REG_LOAD_HIGH: begin
                    reg_rdata[3:0] <= load_high;
                end
                block_ram_tile_pkg::REG_STATUS: begin
                    reg_rdata[block_ram_tile_pkg::ST_EMPTY_BIT] <= fifo_empty;
                    reg_rdata[block_ram_tile_pkg::ST_FULL_BIT] <= fifo_full;
                    reg_rdata[block_ram_tile_pkg::ST_CLAMP_BIT] <=
                        ratio_clamped;
                    reg_rdata[block_ram_tile_pkg::ST_COUNT_LSB +: 13] <= count;
                end
                default: begin
                    reg_rdata <= 32'h0000_0000;
                end
            endcase
        end
    end
endmodule

// [block_ram_tile_checker.sv]
// Port-level assertions for the block RAM tile
`timescale 1ns/1ps
module block_ram_tile_checker (
    input wire logic clock,
    input wire logic reset,
    input wire logic [4:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic a_enable,
    input wire logic [35:0] a_rdata,
    input wire logic [35:0] b_rdata,
    input wire logic push_valid,
    input wire logic push_ready,
    input wire logic pop_request,
    input wire logic pop_valid,
    input wire logic [35:0] pop_data,
    input wire logic fifo_full,
    input wire logic fifo_empty
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    sequence a_idle;
        !a_enable && !reg_write;
    endsequence
    sequence pop_empty;
        pop_request && fifo_empty;
    endsequence
    reset_values_a: assert property ($fell(reset) |-> !pop_valid &&
        fifo_empty && !fifo_full && push_ready && a_rdata == 36'h0 &&
        b_rdata == 36'h0 && reg_rdata == 32'h0)
        else $error("outputs not cleared by reset");
    unmapped_zero_a: assert property (reg_read && reg_addr > 5'h10
        |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
    rdata_hold_a: assert property (!reg_read |=> $stable(reg_rdata))
        else $error("register read data moved");
    flag_excl_a: assert property (!(fifo_full && fifo_empty))
        else $error("full and empty together");
    pop_cause_a: assert property (pop_valid |-> $past(pop_request) &&
        !$past(fifo_empty)) else $error("pop answer without pop");
    pop_refused_a: assert property (pop_empty |=> !pop_valid)
        else $error("pop answered while empty");
    pop_hold_a: assert property (!pop_request |=> $stable(pop_data))
        else $error("pop data moved without pop");
    ready_fall_a: assert property ($fell(push_ready) |->
        $past(push_valid) && $past(push_ready))
        else $error("push ready fell without push");
    full_hold_a: assert property (fifo_full && !pop_request &&
        !reg_write |=> fifo_full) else $error("full flag dropped");
    port_hold_a: assert property (a_idle [*2] |=> $stable(a_rdata))
        else $error("port A output moved while idle");
endmodule

bind block_ram_tile block_ram_tile_checker chk (.*);

// [stream_source.sv]
// User-logic word source feeding the tile's push stream
`timescale 1ns/1ps
module stream_source (
    input wire logic clock,
    input wire logic push_ready,
    output logic push_valid,
    output logic [35:0] push_data
);
    initial begin
        push_valid = 1'b0;
        push_data = 36'h0;
    end
    // Holds the word until taken; gives up after bound cycles
    task automatic send(input logic [35:0] word, input int bound,
            output bit taken);
        int n;
        taken = 1'b0;
        n = 0;
        @(posedge clock);
        push_valid <= 1'b1;
        push_data <= word;
        while (!taken && n < bound) begin
            @(negedge clock);
            taken = (push_ready === 1'b1);
            @(posedge clock);
            n++;
        end
        push_valid <= 1'b0;
        // Released data never repeats the last word
        push_data <= ~word;
    endtask
endmodule

// [block_ram_tile_test.sv]
// Self-checking bench for the block RAM tile
`timescale 1ns/1ps
module block_ram_tile_test;
    localparam logic [35:0] D0 = 36'h000000077;
    localparam logic [35:0] D1 = 36'hA5A5A5A5A;
    localparam logic [35:0] D2 = 36'h5A5A5A5A5;
    localparam logic [35:0] WORD = 36'h900000000;
    localparam logic [4:0] CFG = block_ram_tile_pkg::REG_CONFIG;
    localparam logic [4:0] STS = block_ram_tile_pkg::REG_STATUS;
    logic clock, reset, reg_write, reg_read;
    logic [4:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic a_enable, a_write, b_enable, b_write;
    logic [11:0] a_addr, b_addr;
    logic [35:0] a_wdata, b_wdata, a_rdata, b_rdata, push_data, pop_data;
    logic push_valid, push_ready, pop_request, pop_valid;
    logic fifo_full, fifo_empty;
    int mismatches;
    int checked;
    bit ok;

    block_ram_tile uut (.*);
    stream_source src (.*);

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [35:0] exp,
            input logic [35:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    task automatic test_done;
        $display("checked %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic reg_wr(input logic [4:0] ad, input logic [31:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic reg_rd(input logic [4:0] ad, input logic [31:0] exp,
            input string name);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= ad;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        check(name, {4'h0, exp}, {4'h0, reg_rdata});
    endtask
    // Both ports get the same address and data; p picks which one runs
    task automatic port_op(input bit p, input bit w, input logic [11:0] ad,
            input logic [35:0] d);
        @(posedge clock);
        a_enable <= !p;
        b_enable <= p;
        a_write <= w;
        b_write <= w;
        a_addr <= ad;
        b_addr <= ad;
        a_wdata <= d;
        b_wdata <= d;
        @(posedge clock);
        a_enable <= 1'b0;
        b_enable <= 1'b0;
        #1;
    endtask
    task automatic pop_one(input logic exp_v);
        @(posedge clock);
        pop_request <= 1'b1;
        @(posedge clock);
        pop_request <= 1'b0;
        #1;
        check("pop valid", {35'h0, exp_v}, {35'h0, pop_valid});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic sc_reset;
        check("empty", 36'h1, {35'h0, fifo_empty});
        check("ready", 36'h1, {35'h0, push_ready});
        reg_rd(CFG, 32'h0, "config");
        reg_rd(STS, 32'h1, "status");
        reg_wr(5'h18, 32'h1F);
        reg_rd(5'h18, 32'h0, "unmapped");
        reg_rd(CFG, 32'h0, "config kept");
    endtask
    task automatic sc_rom;
        reg_wr(CFG, 32'h114);
        reg_wr(block_ram_tile_pkg::REG_LOAD_ADDR, 32'h2);
        reg_wr(block_ram_tile_pkg::REG_LOAD_HIGH, 32'hC);
        reg_wr(block_ram_tile_pkg::REG_LOAD_LOW, 32'h12345678);
        reg_wr(block_ram_tile_pkg::REG_LOAD_HIGH, 32'h3);
        reg_wr(block_ram_tile_pkg::REG_LOAD_LOW, 32'h87654321);
        port_op(0, 1, 12'h2, D1);
        check("rom write", 36'hC12345678, a_rdata);
        port_op(0, 0, 12'h3, 36'h0);
        check("rom next", 36'h387654321, a_rdata);
        port_op(0, 0, 12'h2, 36'h0);
        check("rom kept", 36'hC12345678, a_rdata);
    endtask
    task automatic sc_write_modes;
        logic [35:0] exp [3];
        exp = '{D0, D2, D1};
        for (int m = 0; m < 3; m++) begin
            reg_wr(CFG, 32'h14 | 32'(m << 5));
            port_op(0, 1, 12'hA, D0);
            port_op(0, 1, 12'h9, D1);
            port_op(0, 0, 12'hA, 36'h0);
            port_op(0, 1, 12'h9, D2);
            check("write out", exp[m], a_rdata);
            port_op(0, 0, 12'h9, 36'h0);
            check("stored", D2, a_rdata);
        end
    endtask
    task automatic sc_outreg;
        reg_wr(CFG, 32'h94);
        port_op(0, 0, 12'hA, 36'h0);
        port_op(0, 0, 12'h9, 36'h0);
        check("latency one", D0, a_rdata);
        @(posedge clock);
        #1;
        check("latency two", D2, a_rdata);
    endtask
    task automatic sc_ratios;
        int w [6] = '{1, 2, 4, 9, 18, 36};
        for (int r = 0; r < 6; r++) begin
            reg_wr(CFG, 32'(r << 2));
            port_op(0, 1, 12'h1, 36'hFFFFFFFFF);
            port_op(0, 0, 12'h1, 36'h0);
            check("width", (36'h1 << w[r]) - 36'h1, a_rdata);
        end
        reg_wr(CFG, 32'h15);
        reg_rd(STS, 32'h5, "clamp");
    endtask
    task automatic sc_dual;
        reg_wr(CFG, 32'h11);
        port_op(0, 1, 12'h14, 36'h2ABCD);
        port_op(1, 0, 12'h14, 36'h0);
        check("b read", 36'h2ABCD, b_rdata);
        port_op(1, 0, 12'h114, 36'h0);
        check("alias", 36'h2ABCD, b_rdata);
        port_op(1, 1, 12'h15, 36'h12345);
        port_op(0, 0, 12'h15, 36'h0);
        check("a read", 36'h12345, a_rdata);
        reg_wr(CFG, 32'h12);
        port_op(1, 1, 12'h14, 36'h1);
        port_op(1, 0, 12'h14, 36'h0);
        check("pseudo b write", 36'h2ABCD, b_rdata);
    endtask
    // Fills array and buffer to refusal, then drains past empty
    task automatic sc_fifo;
        reg_wr(CFG, 32'h17);
        for (int i = 0; i < 132; i++) begin
            src.send(WORD | 36'(i), 20, ok);
            check("push taken", 36'h1, {35'h0, ok});
        end
        repeat (3) @(posedge clock);
        #1;
        check("full", 36'h1, {35'h0, fifo_full});
        reg_rd(STS, 32'h800002, "count");
        src.send(36'h0, 5, ok);
        check("push refused", 36'h0, {35'h0, ok});
        for (int i = 0; i < 132; i++) begin
            pop_one(1'b1);
            check("pop data", WORD | 36'(i), pop_data);
        end
        pop_one(1'b0);
        check("pop kept", WORD | 36'd131, pop_data);
        check("drained", 36'h1, {35'h0, fifo_empty});
    endtask

    initial begin
        reset = 1'b1;
        {reg_write, reg_read, a_enable, a_write, b_enable, b_write} = 6'h0;
        {reg_addr, reg_wdata, a_addr, b_addr} = 61'h0;
        {a_wdata, b_wdata} = 72'h0;
        pop_request = 1'b0;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        #1;
        sc_reset;
        sc_rom;
        sc_write_modes;
        sc_outreg;
        sc_ratios;
        sc_dual;
        sc_fifo;
        test_done;
    end
    initial begin
        repeat (100000) @(posedge clock);
        mismatches++;
        test_done;
    end
endmodule
